// ---- rtcha_pkg.sv ----
/*
 * constants and types for the rtc host access sequencer.
 * assumes a 25 mhz system clock and a four-wire serial rtc whose
 * si and so pins may be tied together as one data line.
 */
package rtcha_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_NS = 40;
    localparam int CLK_KHZ = 25000;
    localparam int SCLK_HALF_NS = 160;
    localparam int HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int DIV_W = 3;
    localparam int PWR_MS = 2000;   // oscillator start and internal init
    localparam int WR_MS = 1000;    // ce high to low on a time write
    localparam int RD_MS = 500;     // ordinary time read
    localparam int STEP_MS = 1000;  // read step after a periodic interrupt
    localparam int PWR_CYC = PWR_MS * CLK_KHZ;
    localparam int WR_CYC = WR_MS * CLK_KHZ;
    localparam int RD_CYC = RD_MS * CLK_KHZ;
    localparam int STEP_CYC = STEP_MS * CLK_KHZ;
    localparam int DL_W = 26;

    ////////////////////////////////////////////////////////////////////////
    // device side
    localparam logic [3:0] DEV_SEC = 4'h0;
    localparam logic [3:0] DEV_CTRL1 = 4'he;
    localparam logic [3:0] DEV_CTRL2 = 4'hf;
    localparam logic [3:0] HDR_WR = 4'h0;
    localparam logic [3:0] HDR_RD = 4'h4;
    localparam logic [2:0] N_TIME = 3'h7;
    localparam logic [2:0] N_SUB = 3'h5;
    localparam int PER_FLAG_BIT = 2;
    localparam int STOP_FLAG_BIT = 4;
    localparam int LOW_SUP_BIT = 6;
    localparam logic [1:0] LVL_MODE = 2'h1;  // low select bit set: level mode

    ////////////////////////////////////////////////////////////////////////
    // own register map, word addresses
    localparam logic [3:0] R_CTRL = 4'h0;
    localparam logic [3:0] R_STAT = 4'h1;
    localparam logic [3:0] R_IST = 4'h2;
    localparam logic [3:0] R_IMSK = 4'h3;
    localparam logic [3:0] R_TIME0 = 4'h4;
    localparam logic [3:0] R_DCTRL2 = 4'hb;
    localparam int C_WR = 0;
    localparam int C_RD = 1;
    localparam int C_LVL = 2;
    localparam int C_VMON = 3;
    localparam int C_SEL = 4;
    localparam int EV_W = 4;
    localparam int E_DONE = 0;
    localparam int E_TMO = 1;
    localparam int E_STOP = 2;
    localparam int E_PER = 3;

    typedef enum logic [2:0] {
        ST_PWR = 3'b000,
        ST_IDLE = 3'b001,
        ST_HDR = 3'b011,
        ST_BYTE = 3'b010,
        ST_END = 3'b110
    } rtcha_st_t;

    typedef enum logic [2:0] {
        J_CHK = 3'h0,
        J_WT = 3'h1,
        J_VCLR = 3'h2,
        J_RT = 3'h3,
        J_CTCLR = 3'h4,
        J_LVL = 3'h5
    } rtcha_job_t;

endpackage

// ---- rtcha_shift.sv ----
/*
 * byte shifter for the serial link, msb first.
 * assumes start is a one-cycle pulse from the sequencer on the same clock
 * and sdi is already synchronised.
 */
`timescale 1ns/1ns
module rtcha_shift import rtcha_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request
    input wire logic start,
    input wire logic drive,
    input wire logic [7:0] tx,
    // link
    input wire logic sdi,
    output logic sclk_q,
    output logic sd_q,
    output logic oe_q,
    // answer
    output logic done_q,
    output logic [7:0] rx_q
);

    logic busy_q;
    logic ph_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic [DIV_W-1:0] div_q;

    ////////////////////////////////////////////////////////////////////////
    // divider and shift, data moves on the falling sclk edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            ph_q <= 1'b0;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            div_q <= '0;
            sclk_q <= 1'b0;
            sd_q <= 1'b0;
            oe_q <= 1'b0;
            done_q <= 1'b0;
            rx_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                busy_q <= 1'b1;
                ph_q <= 1'b0;
                bit_q <= 3'h0;
                sh_q <= tx;
                sd_q <= tx[7];
                oe_q <= drive;
                div_q <= '0;
                sclk_q <= 1'b0;
            end else if (busy_q) begin
                if (div_q == DIV_W'(HALF_CYC - 1)) begin
                    div_q <= '0;
                    if (!ph_q) begin
                        sclk_q <= 1'b1;
                        rx_q <= {rx_q[6:0], sdi};  // sample on rising edge
                        ph_q <= 1'b1;
                    end else begin
                        sclk_q <= 1'b0;
                        ph_q <= 1'b0;
                        if (bit_q == 3'h7) begin
                            busy_q <= 1'b0;
                            done_q <= 1'b1;
                            oe_q <= 1'b0;  // free the shared data line
                        end else begin
                            bit_q <= bit_q + 3'h1;
                            sh_q <= {sh_q[6:0], 1'b0};
                            sd_q <= sh_q[6];
                        end
                    end
                end else begin
                    div_q <= div_q + DIV_W'(1);
                end
            end
        end
    end

endmodule

// ---- rtcha_top.sv ----
/*
 * host side sequencer for a four-wire serial real-time clock.
 * software drives it over avalon-mm with waitrequest; it runs power-on
 * checks, time write and read bursts and periodic-interrupt reads.
 * assumes the rtc irq pin, data-in and host failure come in asynchronously.
 */
// Local design decisions: register access over Avalon-MM and the address map.
// Operation
// - host keeps ce low while supply rises from zero volts.
// - host drops ce at once when it fails or shuts down.
// - on a three-wire bus si and so share one data line.
// - host waits two seconds after power-on before any access.
// - with supply monitor, host writes low-supply flag zero after seconds write.
// - ce stays high until seconds through year are written in one burst.
// - a time write finishes within one second of ce rising.
// - an ordinary time read finishes within half a second.
// - host selects level mode and clears the periodic flag after each interrupt.
// - the read step after a periodic interrupt ends within one second.
// - first read after a time write reads all counters, later ones a subset.
`timescale 1ns/1ns
module rtcha_top import rtcha_pkg::*; #(
    parameter int PWR_WAIT = PWR_CYC,
    parameter int WR_LIM = WR_CYC,
    parameter int RD_LIM = RD_CYC,
    parameter int STEP_LIM = STEP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    // rtc link
    output logic ce,
    output logic sclk,
    output logic sdio_o,
    output logic sdio_oe,
    input wire logic sdio_i,
    input wire logic irq_output_n,
    // host health
    input wire logic host_fail
);

    logic rs1_q, rst_n;
    logic sdi_m_q, sdi_s_q, irqn_m_q, irqn_s_q, irqn_d_q, fail_m_q, fail_s_q;
    logic wait_q, irq_q, ce_q, go_q, rd_q, per_q;
    logic [31:0] rdata_q;
    logic [EV_W-1:0] ist_q, imsk_q, ev_q;
    logic vmon_q, lvl_on_q, init_q, need_q, full_q;
    logic [1:0] sel_q;
    logic req_wr_q, req_rd_q, req_lvl_q, pend_q;
    logic [7:0] time_q [N_TIME];
    logic [7:0] ctrl2_q, one_q, tx_d, rx;
    rtcha_st_t st_q;
    rtcha_job_t job_q;
    logic [3:0] addr_q;
    logic [2:0] n_q, idx_q;
    logic [DL_W-1:0] dl_q;
    logic sh_done, wr_en, cap;

    ////////////////////////////////////////////////////////////////////////
    // reset release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end

    // two-flop synchronisers on outside inputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sdi_m_q <= 1'b0;
            sdi_s_q <= 1'b0;
            irqn_m_q <= 1'b1;
            irqn_s_q <= 1'b1;
            irqn_d_q <= 1'b1;
            fail_m_q <= 1'b0;
            fail_s_q <= 1'b0;
        end else begin
            sdi_m_q <= sdio_i;
            sdi_s_q <= sdi_m_q;
            irqn_m_q <= irq_output_n;
            irqn_s_q <= irqn_m_q;
            irqn_d_q <= irqn_s_q;
            fail_m_q <= host_fail;
            fail_s_q <= fail_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus slave: answer one cycle after the request appears
    assign wr_en = write & ~wait_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            wait_q <= ~((read | write) & wait_q);
            if (read & wait_q) begin
                unique case (address)
                    R_CTRL: rdata_q <= {26'h0, sel_q, vmon_q, lvl_on_q, 2'h0};
                    R_STAT: rdata_q <= {27'h0, full_q, need_q, lvl_on_q, init_q,
                                        st_q != ST_IDLE};
                    R_IST: rdata_q <= {28'h0, ist_q};
                    R_IMSK: rdata_q <= {28'h0, imsk_q};
                    R_DCTRL2: rdata_q <= {24'h0, ctrl2_q};
                    default: begin
                        if (address >= R_TIME0 && address < R_TIME0 + 4'(N_TIME)) begin
                            rdata_q <= {24'h0, time_q[3'(address - R_TIME0)]};
                        end else begin
                            rdata_q <= 32'h0;  // unmapped reads zero
                        end
                    end
                endcase
            end
        end
    end

    // configuration and command requests, a new request wins over its take
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vmon_q <= 1'b0;
            sel_q <= 2'h0;
            imsk_q <= '0;
            req_wr_q <= 1'b0;
            req_rd_q <= 1'b0;
            req_lvl_q <= 1'b0;
        end else begin
            if (st_q == ST_IDLE && !pend_q) begin
                if (req_lvl_q) begin
                    req_lvl_q <= 1'b0;
                end else if (req_wr_q) begin
                    req_wr_q <= 1'b0;
                end else if (!need_q) begin
                    req_rd_q <= 1'b0;
                end
            end
            if (wr_en && address == R_CTRL) begin
                vmon_q <= writedata[C_VMON];
                sel_q <= writedata[C_SEL +: 2];
                if (writedata[C_WR]) req_wr_q <= 1'b1;
                if (writedata[C_RD]) req_rd_q <= 1'b1;
                if (writedata[C_LVL]) req_lvl_q <= 1'b1;
            end
            if (wr_en && address == R_IMSK) imsk_q <= writedata[EV_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky events, write one to clear, set beats clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ist_q <= '0;
            irq_q <= 1'b0;
        end else begin
            if (wr_en && address == R_IST) begin
                ist_q <= (ist_q & ~writedata[EV_W-1:0]) | ev_q;
            end else begin
                ist_q <= ist_q | ev_q;
            end
            irq_q <= |(ist_q & imsk_q);
        end
    end

    // periodic interrupt: falling edge of the device irq line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
        end else if (lvl_on_q && irqn_d_q && !irqn_s_q) begin
            pend_q <= 1'b1;
        end else if (st_q == ST_IDLE) begin
            pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // time counter images: software writes, device reads land here
    assign cap = (st_q == ST_BYTE) & sh_done & rd_q & (job_q == J_RT);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N_TIME; i++) time_q[i] <= 8'h00;
        end else if (cap) begin
            time_q[idx_q] <= rx;
        end else if (wr_en && address >= R_TIME0 && address < R_TIME0 + 4'(N_TIME)) begin
            time_q[3'(address - R_TIME0)] <= writedata[7:0];
        end
    end

    // byte to send: header, then burst data or single value
    always_comb begin
        if (st_q == ST_HDR) begin
            tx_d = {addr_q, rd_q ? HDR_RD : HDR_WR};
        end else if (job_q == J_WT) begin
            tx_d = time_q[idx_q];
        end else begin
            tx_d = one_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // access sequencer
    task automatic launch(input rtcha_job_t j, input logic [3:0] a, input logic r,
                          input logic [2:0] n, input logic [7:0] v, input int lim);
        job_q <= j;
        addr_q <= a;
        rd_q <= r;
        n_q <= n;
        one_q <= v;
        dl_q <= DL_W'(lim);
        idx_q <= 3'h0;
        ce_q <= 1'b1;
        go_q <= 1'b1;
        st_q <= ST_HDR;
    endtask

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_PWR;
            job_q <= J_CHK;
            addr_q <= 4'h0;
            rd_q <= 1'b0;
            n_q <= 3'h0;
            one_q <= 8'h00;
            idx_q <= 3'h0;
            dl_q <= DL_W'(PWR_WAIT);
            ce_q <= 1'b0;
            go_q <= 1'b0;
            per_q <= 1'b0;
            ev_q <= '0;
            ctrl2_q <= 8'h00;
            init_q <= 1'b0;
            need_q <= 1'b0;
            full_q <= 1'b1;
            lvl_on_q <= 1'b0;
        end else begin
            go_q <= 1'b0;
            ev_q <= '0;
            if (fail_s_q) begin
                ce_q <= 1'b0;
                if (st_q != ST_PWR) st_q <= ST_IDLE;
            end else begin
                unique case (st_q)
                    ST_PWR: begin
                        if (dl_q == '0) begin
                            launch(J_CHK, DEV_CTRL2, 1'b1, 3'h1, 8'h00, RD_LIM);
                        end else begin
                            dl_q <= dl_q - DL_W'(1);
                        end
                    end
                    ST_IDLE: begin
                        if (pend_q) begin
                            per_q <= 1'b1;
                            launch(J_RT, DEV_SEC, 1'b1, full_q ? N_TIME : N_SUB,
                                   8'h00, STEP_LIM);
                        end else if (req_lvl_q) begin
                            launch(J_LVL, DEV_CTRL1, 1'b0, 3'h1,
                                   {5'h0, LVL_MODE[0], sel_q}, WR_LIM);
                        end else if (req_wr_q) begin
                            launch(J_WT, DEV_SEC, 1'b0, N_TIME, 8'h00, WR_LIM);
                        end else if (req_rd_q && !need_q) begin
                            per_q <= 1'b0;
                            launch(J_RT, DEV_SEC, 1'b1, full_q ? N_TIME : N_SUB,
                                   8'h00, RD_LIM);
                        end
                    end
                    ST_HDR, ST_BYTE: begin
                        dl_q <= dl_q - DL_W'(1);
                        if (dl_q == '0) begin
                            ce_q <= 1'b0;
                            ev_q[E_TMO] <= 1'b1;
                            st_q <= ST_IDLE;
                        end else if (sh_done) begin
                            if (st_q == ST_HDR) begin
                                go_q <= 1'b1;
                                st_q <= ST_BYTE;
                            end else if (idx_q == n_q - 3'h1) begin
                                if (job_q == J_CHK) ctrl2_q <= rx;
                                ce_q <= 1'b0;  // whole burst under one ce
                                st_q <= ST_END;
                            end else begin
                                idx_q <= idx_q + 3'h1;
                                go_q <= 1'b1;
                            end
                        end
                    end
                    ST_END: begin
                        st_q <= ST_IDLE;
                        unique case (job_q)
                            J_CHK: begin
                                init_q <= 1'b1;
                                if (ctrl2_q[STOP_FLAG_BIT]) begin
                                    need_q <= 1'b1;
                                    ev_q[E_STOP] <= 1'b1;
                                end
                            end
                            J_WT: begin
                                need_q <= 1'b0;
                                full_q <= 1'b1;
                                if (vmon_q) begin
                                    launch(J_VCLR, DEV_CTRL2, 1'b0, 3'h1,
                                           (ctrl2_q & ~(8'h01 << LOW_SUP_BIT))
                                           | (8'h01 << PER_FLAG_BIT), WR_LIM);
                                end else begin
                                    ev_q[E_DONE] <= 1'b1;
                                end
                            end
                            J_RT: begin
                                full_q <= 1'b0;
                                if (per_q) begin
                                    launch(J_CTCLR, DEV_CTRL2, 1'b0, 3'h1,
                                           ctrl2_q & ~(8'h01 << PER_FLAG_BIT),
                                           WR_LIM);
                                end else begin
                                    ev_q[E_DONE] <= 1'b1;
                                end
                            end
                            J_CTCLR: ev_q[E_PER] <= 1'b1;
                            J_LVL: begin
                                lvl_on_q <= 1'b1;
                                ev_q[E_DONE] <= 1'b1;
                            end
                            default: ev_q[E_DONE] <= 1'b1;
                        endcase
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial engine, si and so share sdio
    rtcha_shift u_shift (
        .clk(clk),
        .rst_n(rst_n),
        .start(go_q),
        .drive(st_q == ST_HDR || !rd_q),
        .tx(tx_d),
        .sdi(sdi_s_q),
        .sclk_q(sclk),
        .sd_q(sdio_o),
        .oe_q(sdio_oe),
        .done_q(sh_done),
        .rx_q(rx)
    );

    // registered outputs
    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign irq = irq_q;
    assign ce = ce_q;

endmodule

// ---- rtcha_assertions.sv ----
/* port checker for the rtc host sequencer.
   assumes the ports of rtcha_top; bound to it at the foot. */
`timescale 1ns/1ns
module rtcha_chk import rtcha_pkg::*; #(
    parameter int PWR_WAIT = PWR_CYC,
    parameter int WR_LIM = WR_CYC
) (
    // clock, reset, bus
    input wire logic clk,
    input wire logic rstn,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    // link and health
    input wire logic ce,
    input wire logic sclk,
    input wire logic sdio_oe,
    input wire logic host_fail
);
    int up_q;
    int run_q;
    // cycles since reset, length of the open frame
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            up_q <= 0;
            run_q <= 0;
        end else begin
            up_q <= (up_q < PWR_WAIT) ? up_q + 1 : up_q;
            run_q <= ce ? run_q + 1 : 0;
        end
    end
    sequence sclk_hi4;
        sclk [*4] ##1 !sclk;
    endsequence
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    pwr_ce_hold_a: assert property (up_q < PWR_WAIT |-> !ce)
        else $error("ce raised during power wait");
    fail_ce_drop_a: assert property (host_fail |-> ##[1:3] !ce)
        else $error("ce kept after host failure");
    frame_len_a: assert property (run_q <= WR_LIM + 2)
        else $error("frame too long");
    sclk_frame_a: assert property (sclk && !host_fail |-> ce)
        else $error("sclk outside frame");
    drive_frame_a: assert property (sdio_oe && !host_fail |-> ce || $past(ce))
        else $error("data driven outside frame");
    sclk_high_a: assert property ($rose(sclk) && !host_fail |-> sclk_hi4)
        else $error("sclk high phase wrong");
    bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus not answered");
    answer_once_a: assert property (!waitrequest |=> waitrequest)
        else $error("answer longer than one cycle");
endmodule
bind rtcha_top rtcha_chk #(.PWR_WAIT(PWR_WAIT), .WR_LIM(WR_LIM)) u_chk (.clk(clk), .rstn(rstn),
    .read(read), .write(write), .waitrequest(waitrequest), .ce(ce), .sclk(sclk),
    .sdio_oe(sdio_oe), .host_fail(host_fail));

// ---- rtcha_dev_model.sv ----
/* behavioural rtc on a tied data line.
   assumes the bench resolves the line with a pull-up. */
`timescale 1ns/1ns
module rtcha_dev_model import rtcha_pkg::*; #(
    parameter int PER = 3000,
    parameter logic STOP0 = 1'b1
) (
    // timebase
    input wire logic clk,
    // serial port
    input wire logic ce,
    input wire logic sclk,
    input wire logic line,
    output logic d_q,
    output logic oe_q,
    // interrupt pin
    output logic irq_n_q
);
    logic [7:0] regs [16];
    logic [7:0] sh;
    logic [7:0] nx;
    logic [3:0] a;
    logic [2:0] bits;
    logic hdr;
    logic rd;
    logic sk;
    logic armed;
    int sub;
    // power-up state
    initial begin
        foreach (regs[i]) regs[i] = 8'h00;
        regs[DEV_CTRL2][LOW_SUP_BIT] = 1'b1; // supply dipped before power-up
        armed = 1'b1;
        {sh, a, bits, rd, sk, d_q, oe_q} = '0;
        hdr = 1'b1;
        irq_n_q = 1'b1;
        sub = 0;
    end
    // frame decode, period tick, level interrupt
    always @(posedge clk) begin
        sk <= sclk;
        nx = {sh[6:0], line};
        sub <= (sub == PER - 1) ? 0 : sub + 1;
        // halt detector is armed at power-up and fires once on the first cycle with ce low, cold start sets the stop flag
        if (armed && !ce) begin
            regs[DEV_CTRL2][STOP_FLAG_BIT] <= STOP0;
            armed <= 1'b0;
        end
        if (sub == PER - 1 && regs[DEV_CTRL1][2])
            regs[DEV_CTRL2][PER_FLAG_BIT] <= 1'b1;
        if (!ce) begin
            bits <= 3'h0;
            hdr <= 1'b1;
            oe_q <= 1'b0;
        end else if (sclk && !sk) begin
            sh <= nx;
            bits <= bits + 3'h1;
            if (bits == 3'h7 && hdr) begin
                a <= nx[7:4];
                rd <= (nx[3:0] == HDR_RD);
                hdr <= 1'b0;
            end else if (bits == 3'h7) begin
                a <= a + 4'h1;
                if (!rd) regs[a] <= nx & ((a == DEV_CTRL2) ? (regs[a] | 8'hfb) : 8'hff);
                if (!rd && a == DEV_SEC) sub <= 0;
            end
        end else if (!sclk && sk && !hdr && rd) begin
            oe_q <= 1'b1;
            d_q <= regs[a][3'h7 - bits];
        end
        irq_n_q <= !(regs[DEV_CTRL2][PER_FLAG_BIT] && regs[DEV_CTRL1][2]);
    end
endmodule

// ---- rtcha_top_tb_top.sv ----
/* self-checking bench for rtcha_top with a model rtc.
   assumes short power and limit counts set by parameters. */
`timescale 1ns/1ns
module rtcha_top_tb_top import rtcha_pkg::*;;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic host_fail = 1'b0;
    logic [31:0] readdata;
    logic waitrequest, irq, ce, sclk, sdio_o, sdio_oe, d_q, oe_q, irq_n;
    wire line;
    logic [31:0] ev_q[$];
    logic [31:0] em_q[$];
    logic [7:0] tv [7];
    int err_count = 0;
    int checks_done = 0;
    always #20 clk = ~clk;
    // tied data line with pull-up
    assign line = sdio_oe ? sdio_o : (oe_q ? d_q : 1'b1);
    rtcha_top #(.PWR_WAIT(200), .WR_LIM(2000), .RD_LIM(2000), .STEP_LIM(2000)) dut (
        .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .ce(ce), .sclk(sclk), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdio_i(line),
        .irq_output_n(irq_n), .host_fail(host_fail));
    rtcha_dev_model #(.STOP0(1'b1)) md (.clk(clk), .ce(ce), .sclk(sclk),
        .line(line), .d_q(d_q), .oe_q(oe_q), .irq_n_q(irq_n));
    task automatic fail_msg(input string s);
        err_count++;
        $display("mismatch at %0t: %s", $time, s);
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) fail_msg($sformatf("got %h expected %h", got, exp));
    endtask
    task automatic cmp_bit(input logic got, input logic exp, input string s);
        checks_done++;
        if (got !== exp) fail_msg(s);
    endtask
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        address <= a;
        read <= !w;
        write <= w;
        writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
        if (n == 40) fail_msg("bus hang");
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v);
        em_q.push_back(m);
        ev_q.push_back(v);
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic wait_sig(input int lim, input logic on_ce);
        int n = 0;
        while ((on_ce ? ce : irq) !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n == lim) fail_msg("wait ran out");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // pair each answered read with the oldest note
    always @(posedge clk) begin
        if (read && waitrequest === 1'b0 && em_q.size() > 0)
            cmp_word(readdata & em_q.pop_front(), ev_q.pop_front());
    end
    // watchdog
    initial begin
        #(40 * 40000);
        fail_msg("watchdog");
        close_out;
    end
    // main sequence
    initial begin
        void'($urandom(83242));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (400) @(posedge clk);
        rd(R_STAT, 32'h8, 32'h8);
        rd(R_IST, 32'h4, 32'h4);
        rd(R_DCTRL2, 32'hff, 32'h50);
        cmp_bit(irq, 1'b0, "masked irq raised");
        bus(R_IMSK, 1'b1, 32'hf);
        repeat (3) @(posedge clk);
        cmp_bit(irq, 1'b1, "unmasked irq low");
        bus(R_IST, 1'b1, 32'hf);
        repeat (3) @(posedge clk);
        cmp_bit(irq, 1'b0, "irq kept after clear");
        foreach (tv[i]) begin
            tv[i] = 8'($urandom);
            bus(R_TIME0 + 4'(i), 1'b1, {24'h0, tv[i]});
        end
        bus(R_CTRL, 1'b1, 32'h9);
        wait_sig(3000, 1'b0);
        foreach (tv[i]) cmp_word({24'h0, md.regs[i]}, {24'h0, tv[i]});
        cmp_bit(md.regs[DEV_CTRL2][LOW_SUP_BIT], 1'b0, "low supply flag set");
        rd(R_IST, 32'h3, 32'h1);
        bus(R_IST, 1'b1, 32'hf);
        bus(R_CTRL, 1'b1, 32'h2);
        wait_sig(3000, 1'b0);
        rd(R_IST, 32'h3, 32'h1);
        bus(R_IST, 1'b1, 32'hf);
        foreach (tv[i]) rd(R_TIME0 + 4'(i), 32'hff, {24'h0, tv[i]});
        rd(R_STAT, 32'h18, 32'h0);
        rd(4'hc, 32'hffffffff, 32'h0);
        bus(R_IMSK, 1'b1, 32'h8);
        bus(R_CTRL, 1'b1, 32'h4);
        wait_sig(8000, 1'b0);
        rd(R_IST, 32'h8, 32'h8);
        cmp_bit(md.regs[DEV_CTRL2][PER_FLAG_BIT], 1'b0, "periodic flag kept");
        cmp_bit(irq_n, 1'b1, "irq pin not released");
        bus(R_IMSK, 1'b1, 32'h0);
        bus(R_CTRL, 1'b1, 32'h1);
        wait_sig(4000, 1'b1);
        host_fail <= 1'b1;
        repeat (4) @(posedge clk);
        cmp_bit(ce, 1'b0, "ce kept after host failure");
        close_out;
    end
endmodule
